// ### hw/composite_video_line_timing.sv
// Purpose: Line and pulse timing generator for a composite video encoder
// Assumes: Field sequencer outside picks the line kind and marks field starts
// Notes: All counts advance on a 27 MHz enable derived from the 200 MHz clock
`default_nettype none

module composite_video_line_timing
  import video_timing_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pal_select_pin,
  input wire logic field_start,
  input wire line_kind_type line_kind_in,
  output logic video_tick,
  output logic line_start,
  output logic half_line_start,
  output logic [COUNT_WIDTH-1:0] h_count,
  output logic [2:0] sync_depth,
  output logic burst_active,
  output logic video_region,
  output logic active_picture,
  output logic front_porch,
  output logic pal_active,
  output line_kind_type line_kind
);

  // Shape depth for a pulse that starts at rel 0 and is width long
  function automatic logic [2:0] pulse_depth(input logic [10:0] rel, input logic [10:0] width);
    logic [2:0] depth;
    depth = 3'h0;
    if (rel < EDGE_RAMP) begin
      depth = 3'(rel + 11'd1);
    end else if (rel < width) begin
      depth = RAMP_DEPTH;
    end else if (rel < width + EDGE_RAMP) begin
      depth = 3'(width + EDGE_RAMP - 11'd1 - rel);
    end
    return depth;
  endfunction : pulse_depth

  logic tick;

  // Enable at the video rate
  video_tick_divider u_tick_divider (
    .clk(clk),
    .rst(rst),
    .video_tick(tick)
  );

  // Standard select pin synchroniser, three stages
  logic pal_s1_reg;
  logic pal_s1_next;
  logic pal_s2_reg;
  logic pal_s2_next;
  logic pal_s3_reg;
  logic pal_s3_next;
  logic pal_stable_reg;
  logic pal_stable_next;

  // Shift the pin in, accept a change once the last two stages agree
  always_comb begin
    pal_s1_next = pal_select_pin;
    pal_s2_next = pal_s1_reg;
    pal_s3_next = pal_s2_reg;
    pal_stable_next = pal_stable_reg;
    if (pal_s2_reg == pal_s3_reg) begin
      pal_stable_next = pal_s3_reg;
    end
  end

  // Synchroniser state, resets to the NTSC level
  always_ff @(posedge clk) begin
    if (rst) begin
      pal_s1_reg <= 1'b0;
      pal_s2_reg <= 1'b0;
      pal_s3_reg <= 1'b0;
      pal_stable_reg <= 1'b0;
    end else begin
      pal_s1_reg <= pal_s1_next;
      pal_s2_reg <= pal_s2_next;
      pal_s3_reg <= pal_s3_next;
      pal_stable_reg <= pal_stable_next;
    end
  end

  // Line counters and per-line settings
  logic [10:0] h_reg;
  logic [10:0] h_next;
  logic [10:0] half_reg;
  logic [10:0] half_next;
  logic pal_reg;
  logic pal_next;
  logic field_pending_reg;
  logic field_pending_next;
  line_kind_type kind_reg;
  line_kind_type kind_next;
  logic wrap;
  logic half_wrap;
  logic [10:0] line_period;
  logic [10:0] half_period;

  // Period of the current standard
  always_comb begin
    line_period = pal_reg ? PAL_LINE_PERIOD : NTSC_LINE_PERIOD;
    half_period = pal_reg ? PAL_HALF_PERIOD : NTSC_HALF_PERIOD;
  end

  // Count video clocks, restart at line and half-line ends
  always_comb begin
    h_next = h_reg;
    half_next = half_reg;
    pal_next = pal_reg;
    kind_next = kind_reg;
    wrap = tick && (h_reg == line_period - 11'd1);
    half_wrap = tick && (half_reg == half_period - 11'd1);
    field_pending_next = field_pending_reg;
    if (tick) begin
      h_next = wrap ? 11'd0 : h_reg + 11'd1;
      half_next = (wrap || half_wrap) ? 11'd0 : half_reg + 11'd1;
    end
    if (wrap) begin
      kind_next = line_kind_in;
      if (field_pending_reg) begin
        pal_next = pal_stable_reg;
        field_pending_next = 1'b0;
      end
    end
    // A new field mark wins over the clear at the wrap
    if (field_start) begin
      field_pending_next = 1'b1;
    end
  end

  // Counter state, starts at the sync reference
  always_ff @(posedge clk) begin
    if (rst) begin
      h_reg <= 11'd0;
      half_reg <= 11'd0;
      pal_reg <= 1'b0;
      field_pending_reg <= 1'b0;
      kind_reg <= LINE_NORMAL;
    end else begin
      h_reg <= h_next;
      half_reg <= half_next;
      pal_reg <= pal_next;
      field_pending_reg <= field_pending_next;
      kind_reg <= kind_next;
    end
  end

  // Per-standard edge positions
  logic [10:0] burst_start;
  logic [10:0] burst_len;
  logic [10:0] video_start;
  logic [10:0] video_len;
  logic [10:0] porch_len;
  logic [10:0] back_margin;
  logic [10:0] front_margin;
  logic [10:0] pulse_start;
  logic [10:0] vpulse_width;

  always_comb begin
    burst_start = pal_reg ? PAL_BURST_START : NTSC_BURST_START;
    burst_len = pal_reg ? PAL_BURST_LEN : NTSC_BURST_LEN;
    video_start = pal_reg ? PAL_VIDEO_START : NTSC_VIDEO_START;
    video_len = pal_reg ? PAL_VIDEO_LEN : NTSC_VIDEO_LEN;
    porch_len = pal_reg ? PAL_FRONT_PORCH : NTSC_FRONT_PORCH;
    back_margin = pal_reg ? PAL_BACK_OVERSCAN : NTSC_BACK_OVERSCAN;
    front_margin = pal_reg ? PAL_FRONT_OVERSCAN : NTSC_FRONT_OVERSCAN;
    pulse_start = pal_reg ? PAL_PULSE_START : NTSC_PULSE_START;
    vpulse_width = pal_reg ? PAL_VPULSE_WIDTH : NTSC_VPULSE_WIDTH;
  end

  // Decoded outputs, registered
  logic line_start_reg;
  logic line_start_next;
  logic half_start_reg;
  logic half_start_next;
  logic [10:0] h_out_reg;
  logic [2:0] depth_reg;
  logic [2:0] depth_next;
  logic burst_reg;
  logic burst_next;
  logic video_reg;
  logic video_next;
  logic picture_reg;
  logic picture_next;
  logic porch_reg;
  logic porch_next;
  logic [10:0] h_out_next;
  logic [10:0] pulse_rel;
  logic [10:0] video_end;
  logic [10:0] burst_end;
  logic [10:0] picture_start;
  logic [10:0] picture_end;
  logic [10:0] porch_end;

  // Window ends and the offset into the half-line from the pulse start
  always_comb begin
    video_end = video_start + video_len;
    burst_end = burst_start + burst_len;
    picture_start = video_start + back_margin;
    picture_end = video_end - front_margin;
    porch_end = video_end + porch_len;
    // Pulse start may lie late in the half-line, so fold the offset
    if (half_reg >= pulse_start) begin
      pulse_rel = half_reg - pulse_start;
    end else begin
      pulse_rel = half_reg + half_period - pulse_start;
    end
  end

  // Next output levels for the current position and line kind
  always_comb begin
    line_start_next = wrap;
    h_out_next = h_reg;
    half_start_next = half_wrap && !wrap;
    burst_next = 1'b0;
    video_next = 1'b0;
    picture_next = 1'b0;
    porch_next = 1'b0;
    depth_next = 3'h0;
    case (kind_reg)
      LINE_EQUALIZING: begin
        depth_next = pulse_depth(pulse_rel, EQ_PULSE_WIDTH);
      end
      LINE_VERTICAL: begin
        // Low for the broad width, then blanking for the rest of the half-line
        depth_next = pulse_depth(pulse_rel, vpulse_width);
      end
      default: begin
        // Burst and picture levels appear on normal lines only
        depth_next = pulse_depth(h_reg, HSYNC_WIDTH);
        burst_next = (h_reg >= burst_start) && (h_reg < burst_end);
        video_next = (h_reg >= video_start) && (h_reg < video_end);
        picture_next = (h_reg >= picture_start) && (h_reg < picture_end);
        porch_next = (h_reg >= video_end) && (h_reg < porch_end);
      end
    endcase
  end

  // Output registers, cleared by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      line_start_reg <= 1'b0;
      half_start_reg <= 1'b0;
      h_out_reg <= 11'd0;
      depth_reg <= 3'h0;
      burst_reg <= 1'b0;
      video_reg <= 1'b0;
      picture_reg <= 1'b0;
      porch_reg <= 1'b0;
    end else begin
      line_start_reg <= line_start_next;
      half_start_reg <= half_start_next;
      h_out_reg <= h_out_next;
      depth_reg <= depth_next;
      burst_reg <= burst_next;
      video_reg <= video_next;
      picture_reg <= picture_next;
      porch_reg <= porch_next;
    end
  end

  // Port drive
  assign video_tick = tick;
  assign line_start = line_start_reg;
  assign half_line_start = half_start_reg;
  assign h_count = h_out_reg;
  assign sync_depth = depth_reg;
  assign burst_active = burst_reg;
  assign video_region = video_reg;
  assign active_picture = picture_reg;
  assign front_porch = porch_reg;
  assign pal_active = pal_reg;
  assign line_kind = kind_reg;

endmodule : composite_video_line_timing

`default_nettype wire

// ### hw/video_timing_pkg.sv
// Purpose: Shared constants and types for the composite video line timing generator
// Assumes: 200 MHz system clock, counts expressed in 27 MHz video clocks
// Notes: Each standard has its own count set, chosen at run time; sync and equalizing widths, edge ramp and vertical interval are shared
`default_nettype none

package video_timing_pkg;

  // Clock rates, used by the fractional divider
  localparam int SYS_CLOCK_MHZ = 200;
  localparam int VIDEO_CLOCK_MHZ = 27;
  localparam int DIV_ACC_WIDTH = 8;

  localparam int COUNT_WIDTH = 11;

  // Full line period
  localparam logic [10:0] NTSC_LINE_PERIOD = 11'd1716;
  localparam logic [10:0] PAL_LINE_PERIOD = 11'd1728;
  // Sync reference to burst start, and burst length
  localparam logic [10:0] NTSC_BURST_START = 11'd144;
  localparam logic [10:0] PAL_BURST_START = 11'd153;
  localparam logic [10:0] NTSC_BURST_LEN = 11'd63;
  localparam logic [10:0] PAL_BURST_LEN = 11'd66;
  // Sync reference to video signal, and video signal length
  localparam logic [10:0] NTSC_VIDEO_START = 11'd255;
  localparam logic [10:0] PAL_VIDEO_START = 11'd279;
  localparam logic [10:0] NTSC_VIDEO_LEN = 11'd1423;
  localparam logic [10:0] PAL_VIDEO_LEN = 11'd1413;
  // Front porch after the video signal
  localparam logic [10:0] NTSC_FRONT_PORCH = 11'd36;
  localparam logic [10:0] PAL_FRONT_PORCH = 11'd39;
  // Horizontal sync width, common to both standards
  localparam logic [10:0] HSYNC_WIDTH = 11'd128;
  // Edge shaping length for all sync, equalizing and vertical pulses
  localparam logic [10:0] EDGE_RAMP = 11'd4;
  localparam logic [2:0] RAMP_DEPTH = 3'h4;
  // Overscan margins
  localparam logic [10:0] NTSC_BACK_OVERSCAN = 11'd9;
  localparam logic [10:0] PAL_BACK_OVERSCAN = 11'd14;
  localparam logic [10:0] NTSC_FRONT_OVERSCAN = 11'd8;
  localparam logic [10:0] PAL_FRONT_OVERSCAN = 11'd13;
  // Half-line period for equalizing and vertical lines
  localparam logic [10:0] NTSC_HALF_PERIOD = 11'd858;
  localparam logic [10:0] PAL_HALF_PERIOD = 11'd864;
  // Equalizing pulse width and its distance from the end of the video signal
  localparam logic [10:0] EQ_PULSE_WIDTH = 11'd64;
  localparam logic [10:0] NTSC_SIGNAL_TO_PULSE = 11'd38;
  localparam logic [10:0] PAL_SIGNAL_TO_PULSE = 11'd41;
  // Broad vertical pulse width and interval
  localparam logic [10:0] NTSC_VPULSE_WIDTH = 11'd730;
  localparam logic [10:0] PAL_VPULSE_WIDTH = 11'd736;
  localparam logic [10:0] VPULSE_INTERVAL = 11'd128;

  // Pulse start inside a half-line, folded back into the line period
  localparam logic [10:0] NTSC_PULSE_START = 11'((NTSC_VIDEO_START + NTSC_VIDEO_LEN
    + NTSC_SIGNAL_TO_PULSE) % NTSC_LINE_PERIOD);
  localparam logic [10:0] PAL_PULSE_START = 11'((PAL_VIDEO_START + PAL_VIDEO_LEN
    + PAL_SIGNAL_TO_PULSE) % PAL_LINE_PERIOD);

  // Kind of line being generated, chosen by the field sequencer outside
  typedef enum logic [1:0] {
    LINE_NORMAL,
    LINE_EQUALIZING,
    LINE_VERTICAL
  } line_kind_type;

endpackage : video_timing_pkg

`default_nettype wire

// ### hw/video_tick_divider.sv
// Purpose: Fractional divider making a 27 MHz enable pulse from the system clock
// Assumes: Rates are integers in MHz with video rate below the system rate
// Notes: Pulse spacing jitters by one cycle, average rate is exact
`default_nettype none

module video_tick_divider
  import video_timing_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  output logic video_tick
);

  logic [DIV_ACC_WIDTH-1:0] acc_reg;
  logic [DIV_ACC_WIDTH-1:0] acc_next;
  logic tick_reg;
  logic tick_next;
  logic [DIV_ACC_WIDTH:0] acc_sum;

  // Accumulate the video rate, wrap at the system rate
  always_comb begin
    acc_sum = {1'b0, acc_reg} + (DIV_ACC_WIDTH+1)'(VIDEO_CLOCK_MHZ);
    tick_next = 1'b0;
    acc_next = acc_sum[DIV_ACC_WIDTH-1:0];
    if (acc_sum >= (DIV_ACC_WIDTH+1)'(SYS_CLOCK_MHZ)) begin
      acc_next = DIV_ACC_WIDTH'(acc_sum - (DIV_ACC_WIDTH+1)'(SYS_CLOCK_MHZ));
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      tick_reg <= tick_next;
    end
  end

  assign video_tick = tick_reg;

endmodule : video_tick_divider

`default_nettype wire

// ### testbench/line_timing_props.sv
// Purpose: Port-level timing checks for the line timing generator
// Assumes: One clock domain, synchronous active-high reset
// Notes: Tick counter restarts at each line start
`default_nettype none

module line_timing_props
  import video_timing_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic video_tick,
  input wire logic line_start,
  input wire logic half_line_start,
  input wire logic [COUNT_WIDTH-1:0] h_count,
  input wire logic [2:0] sync_depth,
  input wire logic burst_active,
  input wire logic video_region,
  input wire logic pal_active,
  input wire line_kind_type line_kind
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] ticks_reg, ticks_next;
  logic pal_reg, pal_next;
  logic [10:0] bst, ben, ven, pst, pnd;
  // Pulse starts of the two half-lines
  assign pst = pal_active ? PAL_PULSE_START : NTSC_PULSE_START;
  assign pnd = pst + (pal_active ? PAL_HALF_PERIOD : NTSC_HALF_PERIOD);
  // Window edges for the standard in use
  assign bst = pal_active ? PAL_BURST_START : NTSC_BURST_START;
  assign ben = bst + (pal_active ? PAL_BURST_LEN : NTSC_BURST_LEN);
  assign ven = (pal_active ? PAL_VIDEO_START + PAL_VIDEO_LEN : NTSC_VIDEO_START + NTSC_VIDEO_LEN);
  // Ticks since line start, standard latched mid-line
  always_comb begin
    ticks_next = line_start ? 12'h000 : ticks_reg + {11'h000, video_tick};
    pal_next = half_line_start ? pal_active : pal_reg;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      ticks_reg <= 12'h000;
      pal_reg <= 1'b0;
    end else begin
      ticks_reg <= ticks_next;
      pal_reg <= pal_next;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  line_length_a: assert property (
    line_start |-> ticks_reg == {1'b0, pal_reg ? PAL_LINE_PERIOD : NTSC_LINE_PERIOD}) else $error("line length wrong");
  half_line_a: assert property (
    half_line_start |-> ticks_reg == {1'b0, pal_active ? PAL_HALF_PERIOD : NTSC_HALF_PERIOD})
    else $error("half line length wrong");
  tick_rate_a: assert property (
    video_tick |=> (!video_tick) [*6] ##[1:2] video_tick) else $error("video tick spacing wrong");
  burst_start_a: assert property (
    $rose(burst_active) |-> h_count == bst) else $error("burst starts at wrong place");
  burst_end_a: assert property (
    $fell(burst_active) |-> h_count == ben) else $error("burst ends at wrong place");
  video_end_a: assert property (
    $fell(video_region) |-> h_count == ven) else $error("video region ends at wrong place");
  sync_width_a: assert property (
    $fell(sync_depth == 3'h4) && line_kind == LINE_NORMAL |-> h_count == HSYNC_WIDTH)
    else $error("sync width wrong");
  edge_ramp_a: assert property (
    $changed(sync_depth) |-> sync_depth == $past(sync_depth) + 3'h1 || sync_depth == $past(sync_depth) - 3'h1)
    else $error("sync level jumped");
  pulse_place_a: assert property (
    line_kind != LINE_NORMAL && sync_depth == 3'h1 && $past(sync_depth) == 3'h0 |-> h_count == pst || h_count == pnd)
    else $error("pulse placed wrong");
  standard_switch_a: assert property (
    $changed(pal_active) |-> h_count < 11'd2 || h_count > 11'd1713) else $error("standard changed mid-line");
  cover property ($rose(pal_active));
  cover property (half_line_start && pal_active);
  cover property (line_kind == LINE_VERTICAL && sync_depth == 3'h4);
endmodule : line_timing_props

bind composite_video_line_timing line_timing_props props (.clk(clk), .rst(rst), .video_tick(video_tick),
  .line_start(line_start), .half_line_start(half_line_start), .h_count(h_count), .sync_depth(sync_depth),
  .burst_active(burst_active), .video_region(video_region), .pal_active(pal_active), .line_kind(line_kind));

`default_nettype wire

// ### testbench/video_receiver_model.sv
// Purpose: Receiver side, measures time spent off blanking per line
// Assumes: One sample per video tick
// Notes: Reports the count at every line start
`default_nettype none

module video_receiver_model
  import video_timing_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic video_tick,
  input wire logic line_start,
  input wire logic [2:0] sync_depth,
  output logic [11:0] sync_ticks
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] count_reg, count_next, ticks_next;
  // Count ticks away from blanking, hand over at line start
  always_comb begin
    count_next = count_reg + {11'h000, video_tick && sync_depth != 3'h0};
    ticks_next = sync_ticks;
    if (line_start) begin
      ticks_next = count_reg;
      count_next = 12'h000;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= 12'h000;
      sync_ticks <= 12'h000;
    end else begin
      count_reg <= count_next;
      sync_ticks <= ticks_next;
    end
  end
endmodule : video_receiver_model

`default_nettype wire

// ### testbench/composite_video_line_timing_bench.sv
// Purpose: Self-checking bench for the line timing generator
// Assumes: Lines 4 and 5 take random stimulus from a fixed seed
// Notes: Each line's settings are applied during the line before it
`default_nettype none

module composite_video_line_timing_bench
  import video_timing_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, pal_select_pin, field_start, video_tick, line_start, half_line_start;
  logic burst_active, video_region, active_picture, front_porch, pal_active, p, f, next_pal, exp_pal;
  logic [10:0] h_count;
  logic [2:0] sync_depth;
  logic [11:0] sync_ticks;
  logic [31:0] seed, r;
  line_kind_type line_kind_in, line_kind, k, exp_kind;
  line_kind_type kind_tab[4] = '{LINE_NORMAL, LINE_EQUALIZING, LINE_VERTICAL, LINE_NORMAL};
  logic [6:0] outs;
  int mismatches, cmp_count, cycles;
  assign outs = {sync_depth, burst_active, video_region, active_picture, front_porch};

  composite_video_line_timing dut (.clk(clk), .rst(rst), .pal_select_pin(pal_select_pin),
    .field_start(field_start), .line_kind_in(line_kind_in), .video_tick(video_tick), .line_start(line_start),
    .half_line_start(half_line_start), .h_count(h_count), .sync_depth(sync_depth), .burst_active(burst_active),
    .video_region(video_region), .active_picture(active_picture), .front_porch(front_porch),
    .pal_active(pal_active), .line_kind(line_kind));
  video_receiver_model rx (.clk(clk), .rst(rst), .video_tick(video_tick), .line_start(line_start),
    .sync_depth(sync_depth), .sync_ticks(sync_ticks));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Expected levels of a normal line at position h
  function automatic logic [6:0] expect_out(input logic [10:0] h, input logic pal);
    logic [10:0] bs, be, vs, ve, ps, pe, fe;
    bs = pal ? PAL_BURST_START : NTSC_BURST_START;
    be = bs + (pal ? PAL_BURST_LEN : NTSC_BURST_LEN);
    vs = pal ? PAL_VIDEO_START : NTSC_VIDEO_START;
    ve = vs + (pal ? PAL_VIDEO_LEN : NTSC_VIDEO_LEN);
    ps = vs + (pal ? PAL_BACK_OVERSCAN : NTSC_BACK_OVERSCAN);
    pe = ve - (pal ? PAL_FRONT_OVERSCAN : NTSC_FRONT_OVERSCAN);
    fe = ve + (pal ? PAL_FRONT_PORCH : NTSC_FRONT_PORCH);
    return {h < HSYNC_WIDTH ? 3'h4 : h < HSYNC_WIDTH + EDGE_RAMP ? 3'(HSYNC_WIDTH + EDGE_RAMP - 11'd1 - h) : 3'h0,
      h >= bs && h < be, h >= vs && h < ve, h >= ps && h < pe, h >= ve && h < fe};
  endfunction : expect_out

  // Ticks off blanking over one whole line, last ramp step already at blanking
  function automatic logic [11:0] exp_ticks(input logic pal, input line_kind_type kd);
    case (kd)
      LINE_EQUALIZING: return 12'(2 * (EQ_PULSE_WIDTH + EDGE_RAMP - 11'd1));
      LINE_VERTICAL: return 12'(2 * ((pal ? PAL_VPULSE_WIDTH : NTSC_VPULSE_WIDTH) + EDGE_RAMP - 11'd1));
      default: return 12'(HSYNC_WIDTH + EDGE_RAMP - 11'd1);
    endcase
  endfunction : exp_ticks

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, expv, seen);
    end
  endtask : check

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      mismatches++;
      end_of_test;
    end
  end

  // Per-tick comparison on normal lines
  always @(posedge clk)
    if (!rst && video_tick && line_kind === LINE_NORMAL && h_count >= 11'd4)
      check("line outputs", {5'h00, outs}, {5'h00, expect_out(h_count, pal_active)});

  // Pulse lines carry no burst, video or porch levels
  always @(posedge clk)
    if (!rst && video_tick && line_kind !== LINE_NORMAL)
      check("pulse line levels", {8'h00, outs[3:0]}, 12'h000);

  initial begin
    seed = 32'd77000;
    rst = 1'b1;
    pal_select_pin = 1'b0;
    field_start = 1'b0;
    line_kind_in = LINE_NORMAL;
    exp_pal = 1'b0;
    exp_kind = LINE_NORMAL;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("reset position", {1'b0, h_count}, 12'h000);
    for (int n = 0; n < 6; n++) begin
      repeat (200) @(posedge clk);
      check("standard and kind", {9'h000, pal_active, line_kind}, {9'h000, exp_pal, exp_kind});
      r = rnd();
      p = n < 4 ? 1'(4'hB >> n) : r[0];
      f = n < 4 ? 1'(4'hE >> n) : r[1];
      k = n < 4 ? kind_tab[n] : line_kind_type'(r[3:2] % 2'd3);
      pal_select_pin <= p;
      line_kind_in <= k;
      repeat (10) @(posedge clk);
      field_start <= f;
      @(posedge clk);
      field_start <= 1'b0;
      next_pal = f ? p : exp_pal;
      do @(posedge clk); while (line_start !== 1'b1);
      @(posedge clk);
      check("sync ticks", sync_ticks, exp_ticks(exp_pal, exp_kind));
      $display("Line %0d done", n);
      exp_pal = next_pal;
      exp_kind = k;
    end
    end_of_test;
  end
endmodule : composite_video_line_timing_bench

`default_nettype wire
